// ---- core/settle_defines.svh ----
// Purpose: constants of the channel settle and clock prescale block
// Assumes: 16-bit registers at the printed 8-bit register addresses
// Notes: offsets, field positions, reset values and timing counts
// Function
// R1: a settle count of zero or one gives a settle wait of 32 reference periods.
// R2: a settle count from two up gives a settle wait of count times 16 reference periods.
// R3: each conversion on a channel starts only after that channel's full settle wait.
// R4: an unsettled amplitude at conversion start raises an amplitude error when reporting is on.
// R5: bits 15 to 12 of a prescale register divide the sensor frequency; zero is reserved.
// R6: the host sets the sensor prescale to two or more for sensors at 8.75 MHz or above.
// R7: bits 9 to 0 of a prescale register divide the device clock into the reference; zero is reserved.
// R8: the host writes zeros to bits 11 and 10 of every prescale register.
// R9: settle registers of channels two and three exist only on the four-channel variant.
// R10: all settle and prescale registers reset to zero, so dividers must be set before converting.
// R11: a conversion lasts the interval count times 16 reference periods; counts below five are reserved.
// R12: each channel's settle wait is a down-counter on its reference tick, reloaded at each channel switch.
`ifndef SETTLE_DEFINES_SVH
`define SETTLE_DEFINES_SVH

`define ADDR_SETTLE_CH1 8'h11
`define ADDR_SETTLE_CH2 8'h12
`define ADDR_SETTLE_CH3 8'h13
`define ADDR_PRESCALE_CH0 8'h14
`define ADDR_PRESCALE_CH1 8'h15

`define FIN_MSB 15
`define FIN_LSB 12
`define RSVD_MSB 11
`define RSVD_LSB 10
`define FREF_MSB 9
`define FREF_LSB 0

`define SETTLE_RESET 16'h0000
`define PRESCALE_RESET 16'h0000

`define SETTLE_SHORT_MAX 16'h0001
`define SETTLE_SHORT_PERIODS 20'h00020
`define PERIOD_MULT_SHIFT 4
`define CONV_COUNT_MIN 16'h0005

`endif

// ---- core/settle_pkg.sv ----
// Purpose: shared types of the channel settle and clock prescale block
// Assumes: sixteen-bit register data
// Notes: field layout mirrors the prescale register bit positions
package settle_pkg;

   // register port request from the serial front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_t;

   // prescale register layout
   typedef struct packed {
      logic [3:0] fin;
      logic [1:0] rsvd;
      logic [9:0] fref;
   } prescale_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETTLE,
      ST_CONVERT
   } conv_state_t;

endpackage : settle_pkg

// ---- core/event_divider.sv ----
// Purpose: divides a stream of input events by a programmable ratio
// Assumes: in_evt synchronous to sys_clk
// Notes: a zero ratio is reserved and yields no ticks
`timescale 1ns/1ps
module event_divider #(
   parameter int W = 10
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic in_evt,
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   // count events, emit one tick per div events
   always_comb begin
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (div == '0) begin
         cnt_next = '0; // reserved ratio clears the divider count and holds it at zero
      end else if (in_evt) begin
         if (cnt_reg >= div - W'(1)) begin
            cnt_next = '0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

   a_zero_div_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n) // R7
      $past(div) == '0 |-> !tick_reg) else $error("divider ticked with a zero ratio");
   a_tick_at_ratio: assert property (@(posedge sys_clk) disable iff (!arst_n) // R5
      tick_reg |-> $past(in_evt) && $past(cnt_reg) == $past(div) - W'(1))
      else $error("divider tick not at end of ratio");
endmodule : event_divider

// ---- core/settle_timer.sv ----
// Purpose: loadable down-counter advanced by a reference tick
// Assumes: load and tick synchronous to sys_clk
// Notes: load wins over a tick in the same cycle
`timescale 1ns/1ps
module settle_timer #(
   parameter int W = 20
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   output logic done
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // reload on switch, else count down one per reference tick
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = load_val; // R12
      end else if (tick && cnt_reg != '0) begin
         cnt_next = cnt_reg - W'(1); // R12
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign done = (cnt_reg == '0);

   a_load_takes: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
      load |=> cnt_reg == $past(load_val)) else $error("timer did not take its load value");
   a_only_ticks_count: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
      !load && !tick |=> $stable(cnt_reg)) else $error("timer moved without a tick");
endmodule : settle_timer

// ---- core/settle_clock_ctrl.sv ----
// Purpose: per-channel settle wait and reference prescale, sensor prescale of channels 0 and 1, conversion sequencing
// Assumes: register port and all pins except the asynchronous reset arst_n synchronous to sys_clk
// Notes: settle count of channel 0 and prescales of channels 2 and 3 arrive as inputs
`timescale 1ns/1ps
`include "settle_defines.svh"
module settle_clock_ctrl #(
   parameter bit FOUR_CH = 1'b1,
   parameter int NUM_CH = 4
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire settle_pkg::reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic [15:0] amplitude_wait_count_ch0,
   input wire settle_pkg::prescale_t prescale_ch2,
   input wire settle_pkg::prescale_t prescale_ch3,
   input wire logic [15:0] conversion_interval_count,
   input wire logic conv_request,
   input wire logic [1:0] conv_channel,
   input wire logic [NUM_CH-1:0] amp_settled,
   input wire logic amp_err_report_en,
   input wire logic [1:0] sensor_in,
   output logic [1:0] sensor_div_tick,
   output logic [NUM_CH-1:0] ref_tick,
   output logic conv_start,
   output logic conv_done,
   output logic amp_error,
   output logic [1:0] active_channel,
   output logic busy
);
   logic [15:0] settle_ch1_reg, settle_ch1_next;
   logic [15:0] settle_ch2_reg, settle_ch2_next;
   logic [15:0] settle_ch3_reg, settle_ch3_next;
   settle_pkg::prescale_t prescale_ch0_reg, prescale_ch0_next;
   settle_pkg::prescale_t prescale_ch1_reg, prescale_ch1_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rd_valid_reg, rd_valid_next;

   // register writes; reserved bits are stored as written
   always_comb begin
      settle_ch1_next = settle_ch1_reg;
      settle_ch2_next = settle_ch2_reg;
      settle_ch3_next = settle_ch3_reg;
      prescale_ch0_next = prescale_ch0_reg;
      prescale_ch1_next = prescale_ch1_reg;
      if (reg_req.wr) begin
         case (reg_req.addr)
            `ADDR_SETTLE_CH1: settle_ch1_next = reg_req.wdata;
            `ADDR_SETTLE_CH2: if (FOUR_CH) settle_ch2_next = reg_req.wdata; // R9
            `ADDR_SETTLE_CH3: if (FOUR_CH) settle_ch3_next = reg_req.wdata; // R9
            `ADDR_PRESCALE_CH0: prescale_ch0_next = reg_req.wdata;
            `ADDR_PRESCALE_CH1: prescale_ch1_next = reg_req.wdata;
            default: ;
         endcase
      end
   end

   // register reads; absent or unmapped addresses read zero
   always_comb begin
      rdata_next = rdata_reg;
      rd_valid_next = reg_req.rd;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `ADDR_SETTLE_CH1: rdata_next = settle_ch1_reg;
            `ADDR_SETTLE_CH2: rdata_next = FOUR_CH ? settle_ch2_reg : 16'h0000; // R9
            `ADDR_SETTLE_CH3: rdata_next = FOUR_CH ? settle_ch3_reg : 16'h0000; // R9
            `ADDR_PRESCALE_CH0: rdata_next = prescale_ch0_reg;
            `ADDR_PRESCALE_CH1: rdata_next = prescale_ch1_reg;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // register storage, cleared by reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         settle_ch1_reg <= `SETTLE_RESET; // R10
         settle_ch2_reg <= `SETTLE_RESET; // R10
         settle_ch3_reg <= `SETTLE_RESET; // R10
         prescale_ch0_reg <= `PRESCALE_RESET; // R10
         prescale_ch1_reg <= `PRESCALE_RESET; // R10
         rdata_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
      end else begin
         settle_ch1_reg <= settle_ch1_next;
         settle_ch2_reg <= settle_ch2_next;
         settle_ch3_reg <= settle_ch3_next;
         prescale_ch0_reg <= prescale_ch0_next;
         prescale_ch1_reg <= prescale_ch1_next;
         rdata_reg <= rdata_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rd_valid = rd_valid_reg;

   // per-channel views of the settle and prescale settings
   logic [15:0] settle_cnt [NUM_CH];
   logic [9:0] fref_div [NUM_CH];
   logic [NUM_CH-1:0] ch_present;
   assign settle_cnt[0] = amplitude_wait_count_ch0;
   assign settle_cnt[1] = settle_ch1_reg;
   assign settle_cnt[2] = settle_ch2_reg;
   assign settle_cnt[3] = settle_ch3_reg;
   assign fref_div[0] = prescale_ch0_reg.fref;
   assign fref_div[1] = prescale_ch1_reg.fref;
   assign fref_div[2] = prescale_ch2.fref;
   assign fref_div[3] = prescale_ch3.fref;
   assign ch_present = FOUR_CH ? 4'hF : 4'h3; // R9

   // sensor edge detect feeding the sensor prescalers
   logic [1:0] sensor_prev_reg, sensor_prev_next;
   logic [1:0] sensor_rise;
   logic [3:0] fin_div [2];
   assign sensor_prev_next = sensor_in;
   assign sensor_rise = sensor_in & ~sensor_prev_reg;
   assign fin_div[0] = prescale_ch0_reg.fin;
   assign fin_div[1] = prescale_ch1_reg.fin;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sensor_prev_reg <= 2'h0;
      end else begin
         sensor_prev_reg <= sensor_prev_next;
      end
   end

   // sequencer signals shared with the per-channel timers
   settle_pkg::conv_state_t state_reg, state_next;
   logic [1:0] ch_reg, ch_next;
   logic [NUM_CH-1:0] settle_load;
   logic [NUM_CH-1:0] settle_done;
   logic [19:0] settle_len [NUM_CH];
   logic accept;
   logic conv_load;
   logic [19:0] conv_len;
   logic conv_timer_done;
   logic [15:0] conv_cnt_eff;

   // sensor prescalers for channels 0 and 1
   for (genvar s = 0; s < 2; s++) begin : g_fin
      event_divider #(.W(4)) u_fin (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .in_evt(sensor_rise[s]),
         .div(fin_div[s]), // R5
         .tick(sensor_div_tick[s])
      );
   end

   // per-channel reference dividers and settle down-counters
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      event_divider #(.W(10)) u_ref (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .in_evt(1'b1),
         .div(fref_div[c]), // R7
         .tick(ref_tick[c])
      );
      // short counts fall back to the fixed minimum
      assign settle_len[c] = (settle_cnt[c] <= `SETTLE_SHORT_MAX) ? `SETTLE_SHORT_PERIODS // R1
         : {settle_cnt[c], 4'h0}; // R2
      assign settle_load[c] = accept && (conv_channel == 2'(c)); // R12
      settle_timer #(.W(20)) u_settle (
         .sys_clk(sys_clk),
         .arst_n(arst_n),
         .load(settle_load[c]),
         .load_val(settle_len[c]),
         .tick(ref_tick[c]),
         .done(settle_done[c])
      );
   end

   // conversion interval, reserved short counts raised to the minimum
   assign conv_cnt_eff = (conversion_interval_count < `CONV_COUNT_MIN) ? `CONV_COUNT_MIN
      : conversion_interval_count;
   assign conv_len = {conv_cnt_eff, 4'h0}; // R11

   settle_timer #(.W(20)) u_conv (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .load(conv_load),
      .load_val(conv_len),
      .tick(ref_tick[ch_reg]),
      .done(conv_timer_done)
   );

   // a request is taken only when idle, the channel exists and its divider is set
   assign accept = (state_reg == settle_pkg::ST_IDLE) && conv_request && ch_present[conv_channel]
      && (fref_div[conv_channel] != 10'h000); // R10

   logic start_reg, start_next;
   logic done_reg, done_next;
   logic amp_err_reg, amp_err_next;

   // sequencer: settle wait, then conversion interval
   always_comb begin
      state_next = state_reg;
      ch_next = ch_reg;
      conv_load = 1'b0;
      start_next = 1'b0;
      done_next = 1'b0;
      amp_err_next = 1'b0;
      case (state_reg)
         settle_pkg::ST_IDLE: begin
            if (accept) begin
               ch_next = conv_channel;
               state_next = settle_pkg::ST_SETTLE;
            end
         end
         settle_pkg::ST_SETTLE: begin
            if (settle_done[ch_reg]) begin // R3
               start_next = 1'b1;
               conv_load = 1'b1;
               amp_err_next = amp_err_report_en && !amp_settled[ch_reg]; // R4
               state_next = settle_pkg::ST_CONVERT;
            end
         end
         settle_pkg::ST_CONVERT: begin
            if (conv_timer_done && !start_reg) begin // R11
               done_next = 1'b1;
               state_next = settle_pkg::ST_IDLE;
            end
         end
         default: state_next = settle_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= settle_pkg::ST_IDLE;
         ch_reg <= 2'h0;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         amp_err_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ch_reg <= ch_next;
         start_reg <= start_next;
         done_reg <= done_next;
         amp_err_reg <= amp_err_next;
      end
   end

   // status outputs, all from flops
   logic busy_reg, busy_next;
   assign busy_next = (state_next != settle_pkg::ST_IDLE);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end

   assign conv_start = start_reg;
   assign conv_done = done_reg;
   assign amp_error = amp_err_reg;
   assign active_channel = ch_reg;
   assign busy = busy_reg;

   // helper for the reset value check
   logic first_reg;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   a_short_settle: assert property (@(posedge sys_clk) disable iff (!arst_n) // R1
      accept && settle_cnt[conv_channel] <= 16'h0001 |-> settle_len[conv_channel] == 20'h00020)
      else $error("short settle count not 32 periods");
   a_long_settle: assert property (@(posedge sys_clk) disable iff (!arst_n) // R2
      accept && settle_cnt[conv_channel] >= 16'h0002
      |-> settle_len[conv_channel] == 20'(settle_cnt[conv_channel]) * 20'h00010)
      else $error("settle length not count times 16");
   a_start_after_wait: assert property (@(posedge sys_clk) disable iff (!arst_n) // R3
      start_reg |-> $past(state_reg == settle_pkg::ST_SETTLE) && $past(settle_done[ch_reg]))
      else $error("conversion started before settle wait ended");
   a_no_early_start: assert property (@(posedge sys_clk) disable iff (!arst_n) // R3
      accept |=> !start_reg [*8]) else $error("conversion started within the minimum wait");
   a_amp_error: assert property (@(posedge sys_clk) disable iff (!arst_n) // R4
      start_reg |-> amp_err_reg == ($past(amp_err_report_en) && !$past(amp_settled[ch_reg])))
      else $error("amplitude error not tied to conversion start");
   a_absent_regs: assert property (@(posedge sys_clk) disable iff (!arst_n) // R9
      !FOUR_CH && reg_req.rd && reg_req.addr == 8'h12 |=> rdata_reg == 16'h0000)
      else $error("absent settle register read nonzero");
   a_reset_zero: assert property (@(posedge sys_clk) // R10
      first_reg && arst_n |-> settle_ch1_reg == 16'h0000 && prescale_ch0_reg == 16'h0000)
      else $error("register not zero after reset");
   a_conv_min: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
      conv_load |-> conv_len >= 20'h00050) else $error("conversion interval below minimum");
   a_zero_div_refused: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
      conv_request && fref_div[conv_channel] == 10'h000 |-> !accept)
      else $error("request accepted with a zero reference divider");
endmodule : settle_clock_ctrl

// ---- bench/config_host.sv ----
// Purpose: host model that programs the settle and prescale registers
// Assumes: decoded register port; requests launched on falling edges
// Notes: keeps the host duties on reserved bits and fast-sensor prescale
`timescale 1ns/1ps
module config_host (
   input wire logic sys_clk,
   output settle_pkg::reg_req_t reg_req,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rd_valid
);
   // idle port from time zero
   initial begin
      reg_req = '0;
   end

   // one write, held across exactly one rising edge
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      logic [15:0] d;
      d = data;
      if (addr == 8'h14 || addr == 8'h15) begin
         d[11:10] = 2'b00;
      end
      @(negedge sys_clk);
      reg_req.wr = 1'b1;
      reg_req.addr = addr;
      reg_req.wdata = d;
      @(negedge sys_clk);
      reg_req = '0;
   endtask : write_reg

   // prescale word built from its fields; fast sensors get at least two
   task automatic set_prescale(input logic [7:0] addr, input logic [3:0] fin, input logic [9:0] fref,
                               input logic fast);
      logic [3:0] f;
      f = fin;
      if (fast && f < 4'h2) begin
         f = 4'h2;
      end
      write_reg(addr, {f, 2'b00, fref});
   endtask : set_prescale

   // one read; answer is taken on the cycle after the request edge
   task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic vld);
      @(negedge sys_clk);
      reg_req.rd = 1'b1;
      reg_req.addr = addr;
      @(negedge sys_clk);
      vld = reg_rd_valid; // valid stands only in the cycle after the request edge
      data = reg_rdata;
      reg_req = '0;
   endtask : read_reg
endmodule : config_host

// ---- bench/tb_settle_clock_ctrl.sv ----
// Purpose: self-checking bench of the settle and prescale block
// Assumes: inputs driven on falling edges; reference divider of one or three
// Notes: conversion timing is judged within a two-cycle pipeline allowance and the free-running reference phase
`timescale 1ns/1ps
module tb_settle_clock_ctrl;
   logic sys_clk;
   logic arst_n;
   settle_pkg::reg_req_t reg_req;
   logic [15:0] reg_rdata;
   logic reg_rd_valid;
   logic [15:0] amplitude_wait_count_ch0;
   settle_pkg::prescale_t prescale_ch2;
   settle_pkg::prescale_t prescale_ch3;
   logic [15:0] conversion_interval_count;
   logic conv_request;
   logic [1:0] conv_channel;
   logic [3:0] amp_settled;
   logic amp_err_report_en;
   logic [1:0] sensor_in;
   logic [1:0] sensor_div_tick;
   logic [3:0] ref_tick;
   logic conv_start;
   logic conv_done;
   logic amp_error;
   logic [1:0] active_channel;
   logic busy;
   int failures;
   int checks;

   settle_clock_ctrl #(.FOUR_CH(1'b1), .NUM_CH(4)) i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .amplitude_wait_count_ch0(amplitude_wait_count_ch0),
      .prescale_ch2(prescale_ch2), .prescale_ch3(prescale_ch3),
      .conversion_interval_count(conversion_interval_count), .conv_request(conv_request),
      .conv_channel(conv_channel), .amp_settled(amp_settled), .amp_err_report_en(amp_err_report_en),
      .sensor_in(sensor_in), .sensor_div_tick(sensor_div_tick), .ref_tick(ref_tick),
      .conv_start(conv_start), .conv_done(conv_done), .amp_error(amp_error),
      .active_channel(active_channel), .busy(busy)
   );

   config_host i_host (
      .sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid)
   );

   // two-channel variant on the same register port and request lines
   logic [15:0] two_ch_rdata;
   settle_clock_ctrl #(.FOUR_CH(1'b0), .NUM_CH(4)) i_dut_two (
      .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(two_ch_rdata), .reg_rd_valid(),
      .amplitude_wait_count_ch0(amplitude_wait_count_ch0), .prescale_ch2(prescale_ch2),
      .prescale_ch3(prescale_ch3), .conversion_interval_count(conversion_interval_count),
      .conv_request(conv_request), .conv_channel(conv_channel), .amp_settled(amp_settled),
      .amp_err_report_en(amp_err_report_en), .sensor_in(sensor_in), .sensor_div_tick(), .ref_tick(),
      .conv_start(), .conv_done(), .amp_error(), .active_channel(), .busy()
   );

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // read one register and compare it
   task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
      logic [15:0] d;
      logic v;
      i_host.read_reg(addr, d, v);
      check(v, 1'b1);
      check(d, exp);
   endtask : rd_chk

   // one conversion: reference divider f, settle and interval lengths in sys_clk cycles
   task automatic conv_run(input logic [1:0] ch, input int f, input int l, input int c, input logic err);
      int n;
      int m;
      @(negedge sys_clk);
      conv_channel = ch;
      conv_request = 1'b1;
      @(negedge sys_clk);
      conv_request = 1'b0;
      n = 0;
      while (conv_start !== 1'b1 && n < 5000) begin
         @(negedge sys_clk);
         n++;
      end
      // the free-running reference may give its first tick up to f-1 clocks early
      check(n >= l - f + 2 && n <= l + 2, 1'b1);
      check(amp_error, err);
      check(active_channel, ch);
      m = 0;
      while (conv_done !== 1'b1 && m < 5000) begin
         @(negedge sys_clk);
         m++;
      end
      check(m >= c - 2 && m <= c + 2, 1'b1);
      repeat (2) @(negedge sys_clk);
      check(busy, 1'b0);
   endtask : conv_run

   // reset values, unmapped place and readback of every register
   task automatic t_registers();
      logic [7:0] a;
      for (int i = 0; i < 5; i++) begin
         a = 8'h11 + 8'(i);
         rd_chk(a, 16'h0000);
      end
      i_host.write_reg(8'h16, 16'hFFFF);
      rd_chk(8'h16, 16'h0000);
      i_host.write_reg(8'h11, 16'h0002);
      i_host.write_reg(8'h12, 16'h0004);
      i_host.write_reg(8'h13, 16'hFFFF);
      i_host.set_prescale(8'h14, 4'h3, 10'h001, 1'b1);
      i_host.set_prescale(8'h15, 4'h0, 10'h003, 1'b0);
      rd_chk(8'h11, 16'h0002);
      rd_chk(8'h12, 16'h0004);
      check(two_ch_rdata, 16'h0000);
      rd_chk(8'h13, 16'hFFFF);
      rd_chk(8'h14, 16'h3001);
      rd_chk(8'h15, 16'h0003);
   endtask : t_registers

   // reference ticks every fref clocks; sensor edges divided by fin
   task automatic t_dividers();
      int r;
      int s0;
      int s1;
      r = 0;
      s0 = 0;
      s1 = 0;
      repeat (30) begin
         @(negedge sys_clk);
         r += int'(ref_tick[1]);
      end
      check(r, 10);
      repeat (9) begin
         @(negedge sys_clk);
         sensor_in = 2'b11;
         s0 += int'(sensor_div_tick[0]);
         s1 += int'(sensor_div_tick[1]);
         @(negedge sys_clk);
         sensor_in = 2'b00;
         s0 += int'(sensor_div_tick[0]);
         s1 += int'(sensor_div_tick[1]);
      end
      repeat (4) begin
         @(negedge sys_clk);
         s0 += int'(sensor_div_tick[0]);
         s1 += int'(sensor_div_tick[1]);
      end
      check(s0, 3);
      check(s1, 0);
   endtask : t_dividers

   // refused requests: reserved divider and request while busy
   task automatic t_refused();
      @(negedge sys_clk);
      conv_channel = 2'd3;
      conv_request = 1'b1;
      @(negedge sys_clk);
      conv_request = 1'b0;
      repeat (10) @(negedge sys_clk);
      check(busy, 1'b0);
      check(conv_start, 1'b0);
      // a second request while busy is dropped
      @(negedge sys_clk);
      conv_channel = 2'd2;
      conv_request = 1'b1;
      @(negedge sys_clk);
      conv_channel = 2'd0;
      @(negedge sys_clk);
      conv_request = 1'b0;
      check(active_channel, 2'd2);
      repeat (160) @(negedge sys_clk);
      check(busy, 1'b0);
   endtask : t_refused

   // watchdog
   initial begin
      #(20000 * 5);
      failures++;
      test_done();
   end

   initial begin
      failures = 0;
      checks = 0;
      arst_n = 1'b0;
      amplitude_wait_count_ch0 = 16'h0000;
      prescale_ch2 = '{fin: 4'h1, rsvd: 2'b00, fref: 10'h001};
      prescale_ch3 = '{fin: 4'h1, rsvd: 2'b00, fref: 10'h000};
      conversion_interval_count = 16'h0005;
      conv_request = 1'b0;
      conv_channel = 2'd0;
      amp_settled = 4'hF;
      amp_err_report_en = 1'b1;
      sensor_in = 2'b00;
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      t_registers();
      t_dividers();
      conv_run(2'd0, 1, 32, 80, 1'b0);
      amplitude_wait_count_ch0 = 16'h0001;
      amp_settled = 4'hE;
      conv_run(2'd0, 1, 32, 80, 1'b1);
      amp_err_report_en = 1'b0;
      amp_settled = 4'h0;
      conversion_interval_count = 16'h0007;
      conv_run(2'd1, 3, 96, 336, 1'b0);
      amp_err_report_en = 1'b1;
      amp_settled = 4'hF;
      conversion_interval_count = 16'h0003;
      conv_run(2'd2, 1, 64, 80, 1'b0);
      t_refused();
      test_done();
   end
endmodule : tb_settle_clock_ctrl
